// ### logic/sesq_pkg.sv
// Servo enable and stop sequencer: constants, types and decode helpers.
// Assumes one 200 MHz clock and an AHB-Lite register port.
// Operation
// - Setting 0 needs servo enable input; setting 1 treats servo as enabled.
// - Setting 0 honours forward limit, forbidding forward motion; 1 ignores it.
// - Setting 0 honours reverse limit, forbidding reverse motion; 1 ignores it.
// - Setting 0 clears alarm at power recovery; 1 keeps the alarm.
// - Stop method 0..5, default 0, used at servo off and overtravel.
// - Method 0 brakes dynamically then releases; method 1 coasts.
// - Methods 2,3: brake or coast at off; overtravel plugs, then servo off.
// - Methods 4,5: brake or coast at off; overtravel plugs, then zero clamp.
// - Setting 0 clears error counter at servo off; 1 keeps it.
package sesq_pkg;

  localparam logic [7:0] SESQ_OFF_CFG      = 8'h00;
  localparam logic [7:0] SESQ_OFF_STATUS   = 8'h04;
  localparam logic [7:0] SESQ_OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] SESQ_OFF_IRQ_MASK = 8'h0C;
  localparam logic [2:0] SESQ_HSIZE_WORD   = 3'h2;

  localparam logic [2:0] SESQ_STOP_MAX     = 3'h5;
  localparam logic [2:0] SESQ_STOP_CLAMP   = 3'h4;
  localparam logic [2:0] SESQ_STOP_PLUG    = 3'h2;

  localparam int SESQ_EV_W       = 5;
  localparam int SESQ_EV_SOFF    = 0;
  localparam int SESQ_EV_OT      = 1;
  localparam int SESQ_EV_STOPPED = 2;
  localparam int SESQ_EV_ALARM   = 3;
  localparam int SESQ_EV_REJECT  = 4;

  typedef struct packed {
    logic       err_keep;
    logic [2:0] stop_method;
    logic       alarm_hold;
    logic       rev_ignore;
    logic       fwd_ignore;
    logic       son_ignore;
  } sesq_cfg_t;

  localparam sesq_cfg_t SESQ_CFG_RESET = 8'h00;

  typedef struct packed {
    logic servo_on;
    logic forward_limit_input;
    logic reverse_limit_input;
    logic move_forward;
    logic move_reverse;
    logic motor_stopped;
    logic fault_event;
    logic power_loss_event;
    logic power_restored;
    logic alarm_reset;
  } sesq_in_t;

  typedef struct packed {
    logic motor_enable;
    logic dynamic_brake;
    logic coast;
    logic plug_brake;
    logic zero_clamp;
    logic forward_allow;
    logic reverse_allow;
    logic error_counter_clear;
  } sesq_drive_t;

  localparam sesq_drive_t SESQ_DRIVE_RESET = 8'h00;

  typedef enum logic [5:0] {
    SESQ_ST_OFF   = 6'h01,
    SESQ_ST_RUN   = 6'h02,
    SESQ_ST_BRAKE = 6'h04,
    SESQ_ST_COAST = 6'h08,
    SESQ_ST_PLUG  = 6'h10,
    SESQ_ST_CLAMP = 6'h20
  } sesq_state_t;

  // Even methods brake at servo off, odd ones coast
  function automatic logic sesq_brakes_at_off(input logic [2:0] m);
    sesq_brakes_at_off = ~m[0];
  endfunction

  function automatic logic sesq_plugs_at_ot(input logic [2:0] m);
    sesq_plugs_at_ot = (m >= SESQ_STOP_PLUG);
  endfunction

  function automatic logic sesq_clamps_at_ot(input logic [2:0] m);
    sesq_clamps_at_ot = (m >= SESQ_STOP_CLAMP);
  endfunction

endpackage

// ### logic/sesq_top.sv
// Servo enable and stop sequencer with AHB-Lite registers and interrupt.
// Assumes single-word AHB-Lite transfers and inputs synchronous to hclk.
`timescale 1ns/100ps
`default_nettype none
module sesq_top
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output var  logic                  hreadyout,
  output var  logic                  hresp,
  output var  logic [31:0]           hrdata,
  input  wire sesq_pkg::sesq_in_t    seq_in,
  output var  sesq_pkg::sesq_drive_t drive,
  output var  logic                  fault_alarm_output,
  output var  logic                  irq
);
  import sesq_pkg::*;

  sesq_cfg_t               cfg_q;
  sesq_cfg_t               cfg_d;
  sesq_state_t             state_q;
  sesq_state_t             state_d;
  sesq_drive_t             drive_d;
  logic                    alarm_q;
  logic                    alarm_d;
  logic [SESQ_EV_W-1:0]    irq_stat_q;
  logic [SESQ_EV_W-1:0]    irq_stat_d;
  logic [SESQ_EV_W-1:0]    irq_mask_q;
  logic [SESQ_EV_W-1:0]    events;
  logic                    wr_pend_q;
  logic [7:0]              wr_addr_q;
  logic [31:0]             rd_data_d;
  logic                    irq_d;

  // Bus decode: zero wait states, word transfers only
  wire logic       addr_ok = hsel && htrans[1] && hready && (hsize == SESQ_HSIZE_WORD);
  wire logic [7:0] offs    = haddr[7:0];
  wire logic       rd_req  = addr_ok && !hwrite;
  wire logic       rd_irq  = rd_req && (offs == SESQ_OFF_IRQ_STAT);
  wire logic       wr_cfg  = wr_pend_q && (wr_addr_q == SESQ_OFF_CFG);
  wire logic       wr_mask = wr_pend_q && (wr_addr_q == SESQ_OFF_IRQ_MASK);

  // Written settings; stop method outside 0..5 is refused
  wire sesq_cfg_t  cfg_wr  = hwdata[7:0];
  wire logic       bad_stop = wr_cfg && (cfg_wr.stop_method > SESQ_STOP_MAX);

  always_comb
  begin
    cfg_d = cfg_q;
    if (wr_cfg)
    begin
      cfg_d = cfg_wr;
      if (bad_stop)
        cfg_d.stop_method = cfg_q.stop_method;
    end
  end

  // Sequence conditions
  wire logic servo_req   = cfg_q.son_ignore || seq_in.servo_on;
  wire logic servo_en    = servo_req && !alarm_q;
  wire logic ot_fwd      = !cfg_q.fwd_ignore && seq_in.forward_limit_input;
  wire logic ot_rev      = !cfg_q.rev_ignore && seq_in.reverse_limit_input;
  wire logic ot_trip     = (ot_fwd && seq_in.move_forward) || (ot_rev && seq_in.move_reverse);
  wire logic method_db   = sesq_brakes_at_off(cfg_q.stop_method);
  wire logic method_plug = sesq_plugs_at_ot(cfg_q.stop_method);
  wire logic method_zc   = sesq_clamps_at_ot(cfg_q.stop_method);
  wire logic stopped     = seq_in.motor_stopped;
  wire logic powered     = (state_q == SESQ_ST_RUN) || (state_q == SESQ_ST_PLUG)
                           || (state_q == SESQ_ST_CLAMP);
  wire sesq_state_t off_stop = method_db ? SESQ_ST_BRAKE : SESQ_ST_COAST;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SESQ_ST_OFF:
        if (servo_en && !ot_trip)
          state_d = SESQ_ST_RUN;
      SESQ_ST_RUN:
        if (!servo_en)
          state_d = off_stop;
        else if (ot_trip)
          state_d = method_plug ? SESQ_ST_PLUG : off_stop;
      SESQ_ST_BRAKE,
      SESQ_ST_COAST:
        if (stopped)
          state_d = SESQ_ST_OFF;
      SESQ_ST_PLUG:
        if (!servo_en)
          state_d = off_stop;
        else if (stopped)
          state_d = method_zc ? SESQ_ST_CLAMP : SESQ_ST_OFF;
      SESQ_ST_CLAMP:
        if (!servo_en)
          state_d = off_stop;
        else if (!ot_trip)
          state_d = SESQ_ST_RUN;
      default:
        state_d = SESQ_ST_OFF;
    endcase
  end

  // Outputs follow the next state so they change with it
  always_comb
  begin
    drive_d                     = SESQ_DRIVE_RESET;
    drive_d.motor_enable        = (state_d == SESQ_ST_RUN) || (state_d == SESQ_ST_PLUG)
                                  || (state_d == SESQ_ST_CLAMP);
    drive_d.dynamic_brake       = (state_d == SESQ_ST_BRAKE);
    drive_d.coast               = (state_d == SESQ_ST_COAST);
    drive_d.plug_brake          = (state_d == SESQ_ST_PLUG);
    drive_d.zero_clamp          = (state_d == SESQ_ST_CLAMP);
    drive_d.forward_allow       = !ot_fwd;
    drive_d.reverse_allow       = !ot_rev;
    drive_d.error_counter_clear = !drive_d.motor_enable && !cfg_d.err_keep;
  end

  // Alarm: any new fault wins over a clear in the same cycle
  wire logic alarm_set = seq_in.fault_event || seq_in.power_loss_event;
  wire logic alarm_clr = seq_in.alarm_reset || (seq_in.power_restored && !cfg_q.alarm_hold);

  always_comb
  begin
    alarm_d = alarm_q;
    if (alarm_clr)
      alarm_d = 1'b0;
    if (alarm_set)
      alarm_d = 1'b1;
  end

  // Sticky events; read of the interrupt status register clears, new events win
  always_comb
  begin
    events                  = '0;
    events[SESQ_EV_SOFF]    = powered && !servo_en;
    events[SESQ_EV_OT]      = (state_q == SESQ_ST_RUN) && servo_en && ot_trip;
    events[SESQ_EV_STOPPED] = stopped && ((state_q == SESQ_ST_BRAKE) || (state_q == SESQ_ST_COAST)
                              || (state_q == SESQ_ST_PLUG));
    events[SESQ_EV_ALARM]   = alarm_set && !alarm_q;
    events[SESQ_EV_REJECT]  = bad_stop;
    irq_stat_d              = (rd_irq ? '0 : irq_stat_q) | events;
    irq_d                   = |(irq_stat_d & irq_mask_q);
  end

  always_comb
  begin
    rd_data_d = 32'h0000_0000;
    case (offs)
      SESQ_OFF_CFG:      rd_data_d[7:0] = cfg_q;
      SESQ_OFF_STATUS:   rd_data_d[14:0] = {alarm_q, drive, state_q};
      SESQ_OFF_IRQ_STAT: rd_data_d[SESQ_EV_W-1:0] = irq_stat_q;
      SESQ_OFF_IRQ_MASK: rd_data_d[SESQ_EV_W-1:0] = irq_mask_q;
      default:           rd_data_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= offs;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (rd_req)
        hrdata <= rd_data_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_q      <= SESQ_CFG_RESET;
      irq_mask_q <= '0;
    end
    else
    begin
      cfg_q <= cfg_d;
      if (wr_mask)
        irq_mask_q <= hwdata[SESQ_EV_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q            <= SESQ_ST_OFF;
      drive              <= SESQ_DRIVE_RESET;
      alarm_q            <= 1'b0;
      fault_alarm_output <= 1'b0;
      irq_stat_q         <= '0;
      irq                <= 1'b0;
    end
    else
    begin
      state_q            <= state_d;
      drive              <= drive_d;
      alarm_q            <= alarm_d;
      fault_alarm_output <= alarm_d;
      irq_stat_q         <= irq_stat_d;
      irq                <= irq_d;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_servo_ignore: assert property (
    (state_q == SESQ_ST_OFF) && cfg_q.son_ignore && !alarm_q && !ot_trip
    |=> drive.motor_enable)
    else $error("servo not enabled with input ignored");

  chk_servo_drop: assert property (
    (state_q == SESQ_ST_RUN) && !cfg_q.son_ignore && !seq_in.servo_on
    |=> !drive.motor_enable ##0 (drive.dynamic_brake || drive.coast))
    else $error("servo kept on without enable input");

  chk_fwd_limit: assert property (
    !cfg_q.fwd_ignore && seq_in.forward_limit_input |=> !drive.forward_allow)
    else $error("forward motion allowed at active limit");

  chk_rev_limit: assert property (
    cfg_q.rev_ignore |=> drive.reverse_allow)
    else $error("reverse limit not ignored");

  chk_alarm_recover: assert property (
    seq_in.power_restored && !cfg_q.alarm_hold && !alarm_set |=> !fault_alarm_output)
    else $error("alarm kept after power recovery");

  chk_alarm_hold: assert property (
    seq_in.power_restored && cfg_q.alarm_hold && alarm_q && !seq_in.alarm_reset
    |=> fault_alarm_output)
    else $error("alarm lost after power recovery");

  chk_stop_range: assert property (
    wr_cfg && bad_stop |=> $stable(cfg_q.stop_method) ##0 irq_stat_q[SESQ_EV_REJECT])
    else $error("out of range stop method taken");

  chk_db_release: assert property (
    (state_q == SESQ_ST_BRAKE) && stopped |=> !drive.dynamic_brake && (state_q == SESQ_ST_OFF))
    else $error("dynamic brake not released");

  chk_plug_off: assert property (
    (state_q == SESQ_ST_PLUG) && servo_en && stopped && !method_zc
    |=> !drive.motor_enable && !drive.plug_brake)
    else $error("servo not off after plug stop");

  chk_plug_clamp: assert property (
    (state_q == SESQ_ST_PLUG) && servo_en && stopped && method_zc
    |=> drive.zero_clamp && drive.motor_enable)
    else $error("no zero clamp after plug stop");

  chk_ot_plug: assert property (
    (state_q == SESQ_ST_RUN) && servo_en && ot_trip && method_plug
    |=> drive.plug_brake && drive.motor_enable)
    else $error("no plug braking at overtravel");

  chk_clamp_exit: assert property (
    (state_q == SESQ_ST_CLAMP) && servo_en && !ot_trip
    |=> drive.motor_enable && !drive.zero_clamp)
    else $error("zero clamp kept after limit cleared");

  chk_coast_free: assert property (
    (state_q == SESQ_ST_RUN) && !servo_en && !method_db
    |=> drive.coast && !drive.dynamic_brake)
    else $error("braking applied where coasting selected");

  chk_fwd_ignore: assert property (
    cfg_q.fwd_ignore |=> drive.forward_allow)
    else $error("forward limit not ignored");

  chk_rev_honour: assert property (
    !cfg_q.rev_ignore && seq_in.reverse_limit_input |=> !drive.reverse_allow)
    else $error("reverse motion allowed at active limit");

  // Clear output and setting register move on the same edge
  chk_err_keep: assert property (
    !drive.motor_enable && cfg_q.err_keep |-> !drive.error_counter_clear)
    else $error("error counter cleared although kept");

  chk_err_clear: assert property (
    drive.motor_enable ##1 !drive.motor_enable && !cfg_q.err_keep |-> drive.error_counter_clear)
    else $error("error counter not cleared at servo off");

endmodule
`default_nettype wire

// ### testbench/sesq_motor_model.sv
// Motor stand-in behind the drive outputs: reports standstill.
// Assumes the bench sets the stopping time in clock cycles.
`timescale 1ns/100ps
`default_nettype none
module sesq_motor_model
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire sesq_pkg::sesq_drive_t drive,
  input  wire logic [7:0]            stop_dly,
  output var  logic                  motor_stopped
);
  import sesq_pkg::*;
  logic [7:0] cnt_q;
  wire logic  slowing = drive.dynamic_brake | drive.coast | drive.plug_brake;
  // A clamped or running motor never reports rest, so no early stop leaks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_q <= 8'h00;
    else if (!slowing)
      cnt_q <= 8'h00;
    else if (cnt_q != stop_dly)
      cnt_q <= cnt_q + 8'h01;
  end
  assign motor_stopped = slowing && (cnt_q == stop_dly);
endmodule
`default_nettype wire

// ### testbench/sesq_top_tb_top.sv
// Self-checking bench for the servo enable and stop sequencer.
// Assumes sesq_top and the motor stand-in model.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("Error %s expected %h seen %h", nm, e, g); \
    end \
  end
module sesq_top_tb_top;
  import sesq_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, alarm, stopped, dp_rd, pin_rd;
  logic [31:0] haddr, hwdata, hrdata, rnd;
  logic [1:0]  htrans;
  logic [7:0]  stop_dly, cfg, e;
  sesq_in_t    si;
  sesq_drive_t drive;
  logic [63:0] notes[$];
  logic [63:0] note;
  int          err_total, checked, seed;
  wire sesq_in_t seq_in = sesq_in_t'(si | {5'h0, stopped, 4'h0});

  always #2.5 hclk = ~hclk;

  sesq_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(SESQ_HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .seq_in(seq_in), .drive(drive),
    .fault_alarm_output(alarm), .irq(irq));
  sesq_motor_model i_motor (.hclk(hclk), .hresetn(hresetn), .drive(drive), .stop_dly(stop_dly),
    .motor_stopped(stopped));

  function automatic logic [31:0] sv(input logic [7:0] d, input logic [5:0] s);
    sv = {18'h0, d, s};
  endfunction

  task close_out();
    if (err_total == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tmo(input int k);
    if (k >= 200)
    begin
      err_total++;
      close_out();
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge hclk);
  endtask

  // Pin values are taken at the next edge, before it updates them
  task automatic pin_chk(input logic [63:0] x);
    notes.push_back(x);
    pin_rd <= 1'b1;
    @(posedge hclk);
    pin_rd <= 1'b0;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [63:0] x);
    int k;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    for (int ph = 0; ph < 2; ph++)
    begin
      k = 0;
      do
      begin
        @(posedge hclk);
        k++;
      end
      while (hreadyout !== 1'b1 && k < 200);
      tmo(k);
      if (ph == 0)
      begin
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        dp_rd  <= !wr;
        if (!wr)
          notes.push_back(x);
      end
    end
    dp_rd <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 64'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0, {32'hFFFF_FFFF, x});
  endtask

  // Waits out any braking, coasting or plugging phase
  task automatic quiet();
    int k;
    k = 0;
    cyc(3);
    while ((drive.dynamic_brake | drive.coast | drive.plug_brake) && k < 200)
    begin
      cyc(1);
      k++;
    end
    tmo(k);
    cyc(2);
  endtask

  always @(posedge hclk)
  begin
    if (dp_rd && hreadyout)
    begin
      note = notes.pop_front();
      `CHK("hrdata", note[31:0], hrdata & note[63:32])
      `CHK("hresp", 1'b0, hresp)
    end
    if (pin_rd)
    begin
      note = notes.pop_front();
      `CHK("irq_alarm", note[31:0], {30'h0, irq, alarm} & note[63:32])
    end
  end

  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    dp_rd = 1'b0;
    pin_rd = 1'b0;
    si = '0;
    stop_dly = 8'h10;
    err_total = 0;
    checked = 0;
    seed = 96;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(SESQ_OFF_CFG, 32'h0);
    rd(SESQ_OFF_STATUS, sv(8'h07, 6'h01));
    rd(8'h10, 32'h0);
    rnd = $random(seed);
    wr(SESQ_OFF_IRQ_MASK, rnd);
    rd(SESQ_OFF_IRQ_MASK, {27'h0, rnd[4:0]});
    for (int m = 0; m < 6; m++)
    begin
      cfg = {m[0], m[2:0], 4'h0};
      e = {7'h0, ~m[0]};
      rnd = $random(seed);
      stop_dly <= 8'h0A + {3'h0, rnd[4:0]};
      wr(SESQ_OFF_CFG, {24'h0, cfg});
      si.servo_on <= 1'b1;
      cyc(3);
      rd(SESQ_OFF_STATUS, sv(8'h86, 6'h02));
      si.servo_on <= 1'b0;
      cyc(3);
      rd(SESQ_OFF_STATUS, sv((m[0] ? 8'h26 : 8'h46) | e, m[0] ? 6'h08 : 6'h04));
      quiet();
      rd(SESQ_OFF_STATUS, sv(8'h06 | e, 6'h01));
      si.servo_on <= 1'b1;
      cyc(3);
      si.forward_limit_input <= 1'b1;
      si.move_forward <= 1'b1;
      cyc(3);
      rd(SESQ_OFF_STATUS, m > 1 ? sv(8'h92, 6'h10) :
        sv((m[0] ? 8'h22 : 8'h42) | e, m[0] ? 6'h08 : 6'h04));
      quiet();
      rd(SESQ_OFF_STATUS, m > 3 ? sv(8'h8A, 6'h20) : sv(8'h02 | e, 6'h01));
      si.forward_limit_input <= 1'b0;
      cyc(2);
      si <= '0;
      quiet();
    end
    wr(SESQ_OFF_CFG, 32'h0000_0007);
    si <= sesq_in_t'(10'h1E0);
    cyc(3);
    rd(SESQ_OFF_STATUS, sv(8'h86, 6'h02));
    wr(SESQ_OFF_CFG, 32'h0);
    quiet();
    rd(SESQ_OFF_STATUS, sv(8'h01, 6'h01));
    si <= '0;
    for (int a = 0; a < 2; a++)
    begin
      wr(SESQ_OFF_CFG, {28'h0, a[0], 3'h0});
      si.power_loss_event <= 1'b1;
      cyc(1);
      si.power_loss_event <= 1'b0;
      si.power_restored <= 1'b1;
      cyc(1);
      si.power_restored <= 1'b0;
      cyc(2);
      pin_chk({32'h0000_0001, 31'h0, a[0]});
      si.alarm_reset <= 1'b1;
      cyc(1);
      si.alarm_reset <= 1'b0;
    end
    rd(SESQ_OFF_IRQ_STAT, 32'h0000_000F);
    wr(SESQ_OFF_IRQ_MASK, 32'h0000_0010);
    wr(SESQ_OFF_CFG, 32'h0000_0050);
    wr(SESQ_OFF_CFG, 32'h0000_00F0);
    rd(SESQ_OFF_CFG, 32'h0000_00D0);
    cyc(2);
    pin_chk({32'h0000_0002, 32'h0000_0002});
    bus(1'b0, SESQ_OFF_IRQ_STAT, 32'h0, {32'h0000_0010, 32'h0000_0010});
    cyc(2);
    pin_chk({32'h0000_0002, 32'h0000_0000});
    wr(SESQ_OFF_IRQ_MASK, 32'h0);
    wr(SESQ_OFF_CFG, 32'h0000_00F0);
    cyc(2);
    pin_chk({32'h0000_0002, 32'h0000_0000});
    close_out();
  end
endmodule
`default_nettype wire
